// *** rtl/istf_status.sv ***
// slave transmit status flags: transmit request and transmit underflow
// assumes scl/sda pins from the bus, fifo empty from same-clock logic,
// and a strobe register port driven on mclk_in
//
// Contract
// - set transmit request when own address matches and direction is read
// - early transmit off: request rises after scl falls in direction bit
// - early transmit on: request rises after scl rises in direction bit
// - interrupt while request flag set and its interrupt enable is one
// - request flag is zero in every other condition
// - underflow flag sits at status bit 1
// - underflow set when master reads while transmit fifo is empty
// - underflow asserted on scl rising edge of the direction bit
// - transmit request flag sits at status bit 2
`timescale 1ns/10ps
module istf_status (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic tx_fifo_empty_in,
	input wire logic [istf_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [istf_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [istf_pkg::DATA_W-1:0] reg_rdata_out,
	output logic slave_tx_request_flag_out,
	output logic slave_tx_underflow_flag_out,
	output logic irq_out
);

	// register offset match
	function automatic logic reg_hit(
		input logic [istf_pkg::ADDR_W-1:0] addr,
		input logic [istf_pkg::ADDR_W-1:0] ofs
	);
		reg_hit = (addr == ofs);
	endfunction

	// flag vector in status layout, one bit per flag
	function automatic logic [istf_pkg::FLAG_W-1:0] flag_vec(
		input logic txq,
		input logic underflow
	);
		logic [istf_pkg::FLAG_W-1:0] v;
		v = '0;
		v[istf_pkg::BIT_TXREQ] = txq;
		v[istf_pkg::BIT_UNDERFLOW] = underflow;
		flag_vec = v;
	endfunction

	// widen a flag vector to a bus word, upper bits zero
	function automatic logic [istf_pkg::DATA_W-1:0] flag_word(
		input logic [istf_pkg::FLAG_W-1:0] v
	);
		logic [istf_pkg::DATA_W-1:0] w;
		w = '0;
		w[istf_pkg::FLAG_W-1:0] = v;
		flag_word = w;
	endfunction

	istf_pkg::istf_pins_t pins;
	istf_pkg::istf_regs_t r;
	istf_pkg::istf_regs_t next_r;

	logic is_match;
	logic set_txq;
	logic set_underflow;
	logic [istf_pkg::FLAG_W-1:0] set_events;
	logic [istf_pkg::FLAG_W-1:0] clr_events;
	logic [istf_pkg::DATA_W-1:0] ctrl_word;
	logic [istf_pkg::DATA_W-1:0] own_word;

	// pin conditioning
	istf_pin_sync u_sync (
		.mclk_in(mclk_in),
		.nrst_in(nrst_in),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.pins_out(pins)
	);

	// address compare on the shifted seven bits
	assign is_match = (r.addr_sr == r.own_addr);

	// transfer tracking and flag timing
	always_comb begin
		next_r = r;
		set_txq = 1'b0;
		set_underflow = 1'b0;

		case (r.state)
			istf_pkg::st_idle: begin
				next_r.txq = 1'b0;
			end
			istf_pkg::st_addr: begin
				next_r.txq = 1'b0;
				if (pins.scl_rise) begin
					if (r.bit_cnt == istf_pkg::RW_BIT_IDX) begin
						// direction bit sampled on this rising edge
						if (is_match && pins.sda == istf_pkg::DIR_READ) begin
							if (tx_fifo_empty_in) begin
								set_underflow = 1'b1;
							end
							if (r.early) begin
								set_txq = 1'b1;
								next_r.state = istf_pkg::st_read;
							end else begin
								next_r.state = istf_pkg::st_rw_wait;
							end
						end else begin
							next_r.state = istf_pkg::st_skip;
						end
					end else begin
						next_r.addr_sr = {r.addr_sr[istf_pkg::OWN_ADDR_W-2:0], pins.sda};
						next_r.bit_cnt = r.bit_cnt + istf_pkg::BITCNT_ONE;
					end
				end
			end
			istf_pkg::st_rw_wait: begin
				// late mode waits for the falling edge closing the direction bit
				if (pins.scl_fall) begin
					set_txq = 1'b1;
					next_r.state = istf_pkg::st_read;
				end
			end
			istf_pkg::st_read: begin
				next_r.txq = r.txq;
			end
			istf_pkg::st_skip: begin
				next_r.txq = 1'b0;
			end
			default: begin
				next_r.state = istf_pkg::st_idle;
				next_r.txq = 1'b0;
			end
		endcase

		if (set_txq) begin
			next_r.txq = 1'b1;
		end
		if (set_underflow) begin
			next_r.underflow = 1'b1;
		end

		// start or repeated start opens a new transfer
		if (pins.start) begin
			next_r.state = istf_pkg::st_addr;
			next_r.bit_cnt = istf_pkg::BITCNT_RST;
			next_r.txq = 1'b0;
			next_r.underflow = 1'b0;
		end else if (pins.stop) begin
			next_r.state = istf_pkg::st_idle;
			next_r.txq = 1'b0;
		end

		// register writes
		if (reg_wr_in) begin
			if (reg_hit(reg_addr_in, istf_pkg::OFS_CTRL)) begin
				next_r.early = reg_wdata_in[istf_pkg::BIT_EARLY];
			end
			if (reg_hit(reg_addr_in, istf_pkg::OFS_MASK)) begin
				next_r.mask = reg_wdata_in[istf_pkg::FLAG_W-1:0];
			end
			if (reg_hit(reg_addr_in, istf_pkg::OFS_OWN_ADDR)) begin
				next_r.own_addr = reg_wdata_in[istf_pkg::OWN_ADDR_W-1:0];
			end
		end

		// sticky events, set wins over the read clear
		next_r.sticky = (r.sticky & ~clr_events) | set_events;

		// read data stands one cycle after the strobe only
		next_r.rdata = '0;
		if (reg_rd_in) begin
			if (reg_hit(reg_addr_in, istf_pkg::OFS_CTRL)) begin
				next_r.rdata = ctrl_word;
			end else if (reg_hit(reg_addr_in, istf_pkg::OFS_STATUS)) begin
				next_r.rdata = flag_word(flag_vec(r.txq, r.underflow));
			end else if (reg_hit(reg_addr_in, istf_pkg::OFS_MASK)) begin
				next_r.rdata = flag_word(r.mask);
			end else if (reg_hit(reg_addr_in, istf_pkg::OFS_IRQ)) begin
				next_r.rdata = flag_word(r.sticky);
			end else if (reg_hit(reg_addr_in, istf_pkg::OFS_OWN_ADDR)) begin
				next_r.rdata = own_word;
			end else begin
				next_r.rdata = '0;
			end
		end
	end

	// event vector and read clear of the interrupt status
	always_comb begin
		set_events = flag_vec(set_txq, set_underflow);
		clr_events = '0;
		if (reg_rd_in && reg_hit(reg_addr_in, istf_pkg::OFS_IRQ)) begin
			clr_events = '1;
		end
	end

	// readback words of the plain configuration registers
	always_comb begin
		ctrl_word = '0;
		ctrl_word[istf_pkg::BIT_EARLY] = r.early;
		own_word = '0;
		own_word[istf_pkg::OWN_ADDR_W-1:0] = r.own_addr;
	end

	// state register
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r.state <= istf_pkg::st_idle;
			r.bit_cnt <= istf_pkg::BITCNT_RST;
			r.addr_sr <= '0;
			r.early <= istf_pkg::EARLY_RST;
			r.own_addr <= istf_pkg::OWN_ADDR_RST;
			r.txq <= 1'b0;
			r.underflow <= 1'b0;
			r.mask <= istf_pkg::MASK_RST;
			r.sticky <= istf_pkg::FLAGS_RST;
			r.rdata <= '0;
		end else begin
			r <= next_r;
		end
	end

	// outputs
	assign reg_rdata_out = r.rdata;
	assign slave_tx_request_flag_out = r.txq;
	assign slave_tx_underflow_flag_out = r.underflow;

	// live request level plus any unmasked sticky event
	assign irq_out = (r.txq & r.mask[istf_pkg::BIT_TXREQ]) | (|(r.sticky & r.mask));

endmodule

// *** pkg/istf_pkg.sv ***
// shared constants and types for the slave transmit status flag block
// assumes a 100 mhz system clock and a plain strobe register port
package istf_pkg;

	// register port geometry
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;

	// register offsets (byte addresses, one word each)
	localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_MASK = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ = 5'h0c;
	localparam logic [ADDR_W-1:0] OFS_OWN_ADDR = 5'h10;

	// field positions of the control register
	localparam int BIT_EARLY = 0;

	// field positions shared by status, mask and interrupt status
	localparam int FLAG_W = 3;
	localparam int BIT_UNDERFLOW = 1;
	localparam int BIT_TXREQ = 2;

	// own slave address
	localparam int OWN_ADDR_W = 7;
	localparam logic [OWN_ADDR_W-1:0] OWN_ADDR_RST = 7'h2a;

	// reset values
	localparam logic EARLY_RST = 1'b0;
	localparam logic [FLAG_W-1:0] MASK_RST = 3'h0;
	localparam logic [FLAG_W-1:0] FLAGS_RST = 3'h0;

	// address byte bit counting: bits 0..6 address, bit 7 direction
	localparam int BITCNT_W = 3;
	localparam logic [BITCNT_W-1:0] BITCNT_RST = 3'h0;
	localparam logic [BITCNT_W-1:0] BITCNT_ONE = 3'h1;
	localparam logic [BITCNT_W-1:0] RW_BIT_IDX = 3'h7;
	localparam logic DIR_READ = 1'b1;

	// conditioned bus pin view handed from the synchroniser
	typedef struct packed {
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} istf_pins_t;

	// transfer tracking states
	typedef enum logic [2:0] {
		st_idle,
		st_addr,
		st_rw_wait,
		st_read,
		st_skip
	} istf_state_t;

	// complete state of the flag block
	typedef struct packed {
		istf_state_t state;
		logic [BITCNT_W-1:0] bit_cnt;
		logic [OWN_ADDR_W-1:0] addr_sr;
		logic early;
		logic [OWN_ADDR_W-1:0] own_addr;
		logic txq;
		logic underflow;
		logic [FLAG_W-1:0] mask;
		logic [FLAG_W-1:0] sticky;
		logic [DATA_W-1:0] rdata;
	} istf_regs_t;

endpackage

// *** rtl/istf_pin_sync.sv ***
// two-flop synchronisers for scl and sda with edge and start/stop detection
// assumes both pins are asynchronous to mclk_in and already resolved wires
`timescale 1ns/10ps
module istf_pin_sync (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output istf_pkg::istf_pins_t pins_out
);

	typedef struct packed {
		logic scl_meta;
		logic scl_sync;
		logic scl_dly;
		logic sda_meta;
		logic sda_sync;
		logic sda_dly;
	} istf_sync_t;

	istf_sync_t r;
	istf_sync_t next_r;

	// shift chains; first stage feeds only the second
	always_comb begin
		next_r = r;
		next_r.scl_meta = scl_in;
		next_r.scl_sync = r.scl_meta;
		next_r.scl_dly = r.scl_sync;
		next_r.sda_meta = sda_in;
		next_r.sda_sync = r.sda_meta;
		next_r.sda_dly = r.sda_sync;
	end

	// idle bus is high on both lines
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r <= '1;
		end else begin
			r <= next_r;
		end
	end

	// conditioned view, all from synchronised stages
	always_comb begin
		pins_out.scl = r.scl_sync;
		pins_out.sda = r.sda_sync;
		pins_out.scl_rise = r.scl_sync & ~r.scl_dly;
		pins_out.scl_fall = ~r.scl_sync & r.scl_dly;
		pins_out.start = r.scl_sync & r.scl_dly & r.sda_dly & ~r.sda_sync;
		pins_out.stop = r.scl_sync & r.scl_dly & ~r.sda_dly & r.sda_sync;
	end

endmodule

// *** bench/istf_checker.sv ***
// assertions on the ports of the slave transmit status flag block
// assumes binding onto istf_status, one clock domain
`timescale 1ns/10ps
module istf_checker (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic tx_fifo_empty_in,
	input wire logic [istf_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [istf_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [istf_pkg::DATA_W-1:0] reg_rdata_out,
	input wire logic slave_tx_request_flag_out,
	input wire logic slave_tx_underflow_flag_out,
	input wire logic irq_out
);
	logic [2:0] mask;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);
	// shadow of the mask register
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in)
			mask <= 3'h0;
		else if (reg_wr_in && reg_addr_in == istf_pkg::OFS_MASK)
			mask <= reg_wdata_in[2:0];
	end
	a_req_on_edge: assert property ($rose(slave_tx_request_flag_out) |-> $past(scl_in, 2) != $past(scl_in, 5))
		else $error("request rose away from a clock edge");
	a_req_clear: assert property ($fell(slave_tx_request_flag_out) |-> $past(scl_in, 2))
		else $error("request cleared outside stop or start");
	a_uf_rise: assert property ($rose(slave_tx_underflow_flag_out) |-> $past(scl_in, 2) && !$past(scl_in, 5))
		else $error("underflow rose off a rising clock");
	a_uf_empty: assert property ($rose(slave_tx_underflow_flag_out) |-> $past(tx_fifo_empty_in))
		else $error("underflow with fifo not empty");
	a_uf_start: assert property ($fell(slave_tx_underflow_flag_out) |-> $past(scl_in, 2) && !$past(sda_in, 2))
		else $error("underflow cleared without start");
	a_irq_req: assert property (slave_tx_request_flag_out && mask[2] |-> irq_out)
		else $error("request enabled but no interrupt");
	a_irq_masked: assert property (irq_out |-> mask != 3'h0)
		else $error("interrupt with all sources masked");
	a_status_bits: assert property (reg_rd_in && reg_addr_in == istf_pkg::OFS_STATUS |=>
		reg_rdata_out == {29'h0, $past(slave_tx_request_flag_out), $past(slave_tx_underflow_flag_out), 1'b0})
		else $error("status read does not match flags");
	a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
		else $error("read data outside read cycle");
endmodule
bind istf_status istf_checker i_istf_checker (.*);

// *** bench/istf_master.sv ***
// behavioural bus master sending one address byte at a time
// assumes pull-ups on both lines and an 80 ns bit period
`timescale 1ns/10ps
module istf_master (
	output logic scl_out,
	output logic sda_out
);
	// idle bus: both lines released high
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// start or repeated start: data falls while clock high
	task automatic start();
		sda_out = 1'b1;
		#20 scl_out = 1'b1;
		#40 sda_out = 1'b0;
		#40;
	endtask
	// eight bits msb first, returns just after the last rising clock
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			scl_out = 1'b0;
			#20 sda_out = b[i];
			#20 scl_out = 1'b1;
			if (i != 0)
				#40;
		end
	endtask
	// drop the clock and release data to its pull-up
	task automatic lo();
		scl_out = 1'b0;
		#20 sda_out = 1'b1;
		#20;
	endtask
	// stop: data rises while clock high
	task automatic stop();
		sda_out = 1'b0;
		#20 scl_out = 1'b1;
		#40 sda_out = 1'b1;
		#40;
	endtask
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the slave transmit status flag block
// assumes the master model drives scl and sda, bench drives the rest
`timescale 1ns/10ps
module testbench;
	logic mclk_in;
	logic nrst_in;
	logic scl;
	logic sda;
	logic empty;
	logic [istf_pkg::ADDR_W-1:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic txq;
	logic uf;
	logic irq;
	logic [31:0] d;
	int n_mismatch;
	int samples_checked;
	istf_status i_istf_status (.mclk_in(mclk_in), .nrst_in(nrst_in), .scl_in(scl), .sda_in(sda),
		.tx_fifo_empty_in(empty), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .slave_tx_request_flag_out(txq), .slave_tx_underflow_flag_out(uf), .irq_out(irq));
	istf_master i_istf_master (.scl_out(scl), .sda_out(sda));
	// clock
	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end
	// compare helpers and verdict
	task automatic fail(input string m);
		n_mismatch++;
		$display("mismatch at %0t: %s", $time, m);
	endtask
	task automatic chk1(input logic g, input logic e, input string m);
		samples_checked++;
		if (g !== e)
			fail(m);
	endtask
	task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string m);
		samples_checked++;
		if (g !== e)
			fail(m);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// register port cycles
	task automatic wr_reg(input logic [istf_pkg::ADDR_W-1:0] a, input logic [31:0] v);
		@(posedge mclk_in);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge mclk_in);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [istf_pkg::ADDR_W-1:0] a, output logic [31:0] v);
		@(posedge mclk_in);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk_in);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	// reset values, unmapped read, mask write
	task automatic reg_test();
		rd_reg(istf_pkg::OFS_CTRL, d);
		chk32(d, 32'h0, "control reset");
		rd_reg(istf_pkg::OFS_OWN_ADDR, d);
		chk32(d, 32'h2a, "own address reset");
		rd_reg(5'h14, d);
		chk32(d, 32'h0, "unmapped read");
		wr_reg(istf_pkg::OFS_MASK, 32'h4);
		rd_reg(istf_pkg::OFS_MASK, d);
		chk32(d, 32'h4, "mask readback");
		$display("register test done");
	endtask
	// one address byte, judged at the direction bit rise, fall and stop
	task automatic xfer(input logic [6:0] a, input logic dir, input logic early, input logic mt, input logic q);
		wr_reg(istf_pkg::OFS_CTRL, {31'h0, early});
		empty <= mt;
		i_istf_master.start();
		chk1(uf, 1'b0, "underflow past start");
		i_istf_master.send({a, dir});
		#50;
		chk1(uf, mt, "underflow at rise");
		chk1(txq, early & q, "request at rise");
		i_istf_master.lo();
		#30;
		chk1(txq, q, "request after fall");
		chk1(irq, q, "interrupt");
		rd_reg(istf_pkg::OFS_IRQ, d);
		chk32(d, {29'h0, q, mt, 1'b0}, "event bits");
		rd_reg(istf_pkg::OFS_STATUS, d);
		chk32(d, {29'h0, q, mt, 1'b0}, "status");
		i_istf_master.stop();
		chk1(txq, 1'b0, "request after stop");
		chk1(uf, mt, "underflow after stop");
		chk1(irq, 1'b0, "interrupt after clear");
		$display("transfer test done");
	endtask
	// hang guard
	initial begin
		#1000000;
		fail("timeout");
		complete_run();
	end
	// main sequence
	initial begin
		nrst_in = 1'b0;
		empty = 1'b0;
		addr = '0;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		n_mismatch = 0;
		samples_checked = 0;
		repeat (4) @(posedge mclk_in);
		nrst_in <= 1'b1;
		repeat (4) @(posedge mclk_in);
		reg_test();
		xfer(7'h2a, 1'b1, 1'b1, 1'b1, 1'b1);
		xfer(7'h2a, 1'b1, 1'b0, 1'b0, 1'b1);
		xfer(7'h15, 1'b1, 1'b1, 1'b0, 1'b0);
		xfer(7'h2a, 1'b0, 1'b1, 1'b0, 1'b0);
		// moved own address and underflow-only interrupt enable
		wr_reg(istf_pkg::OFS_OWN_ADDR, 32'h15);
		wr_reg(istf_pkg::OFS_MASK, 32'h2);
		rd_reg(istf_pkg::OFS_OWN_ADDR, d);
		chk32(d, 32'h15, "own address readback");
		xfer(7'h15, 1'b1, 1'b0, 1'b1, 1'b1);
		xfer(7'h2a, 1'b1, 1'b1, 1'b0, 1'b0);
		complete_run();
	end
endmodule
